/* File: rtcai_pkg.sv */
/*
 Constants of the alarm interrupt block: register addresses, bit
 positions, field masks and serial mode codes.
 Assumes all users import the whole package.
*/
package rtcai_pkg;
  localparam int RTCAI_AW = 4;
  localparam int RTCAI_DW = 8;
  // Register addresses
  localparam logic [3:0] RTCAI_A_MIN = 4'h1;
  localparam logic [3:0] RTCAI_A_HOUR = 4'h2;
  localparam logic [3:0] RTCAI_A_WDAY = 4'h3;
  localparam logic [3:0] RTCAI_A_DATE = 4'h4;
  localparam logic [3:0] RTCAI_A_MIN_ALM = 4'h8;
  localparam logic [3:0] RTCAI_A_HOUR_ALM = 4'h9;
  localparam logic [3:0] RTCAI_A_WD_ALM = 4'ha;
  localparam logic [3:0] RTCAI_A_EXT = 4'hd;
  localparam logic [3:0] RTCAI_A_FLAG = 4'he;
  localparam logic [3:0] RTCAI_A_CTRL = 4'hf;
  // Bit positions
  localparam int RTCAI_B_MASK = 7;
  localparam int RTCAI_B_WEEK_OR_DATE_SELECT = 6;
  localparam int RTCAI_B_TRUN = 4;
  localparam int RTCAI_B_CSEL = 2;
  localparam int RTCAI_B_TSRC = 0;
  localparam int RTCAI_B_TF = 4;
  localparam int RTCAI_B_AF = 3;
  localparam int RTCAI_B_VLF = 1;
  localparam int RTCAI_B_TIE = 4;
  localparam int RTCAI_B_AIE = 3;
  localparam int RTCAI_B_STOP = 1;
  // Comparison field masks
  localparam logic [7:0] RTCAI_MIN_BITS = 8'h7f;
  localparam logic [7:0] RTCAI_HD_BITS = 8'h3f;
  localparam logic [7:0] RTCAI_WDAY_BITS = 8'h7f;
  localparam logic [7:0] RTCAI_ZERO = 8'h00;
  // Serial mode codes
  localparam logic [3:0] RTCAI_MODE_WR = 4'h1;
  localparam logic [3:0] RTCAI_MODE_RD = 4'h9;
  localparam logic [2:0] RTCAI_LAST_BIT = 3'h7;
  typedef enum logic [1:0] {
    RTCAI_S_CMD, RTCAI_S_WR, RTCAI_S_RD, RTCAI_S_IGN
  } rtcai_ser_t;
endpackage

/* File: rtcai_match.sv */
/*
 Alarm comparator: checks the alarm registers against the time counters.
 Assumes counter values are BCD and stable while compared.
*/
`timescale 1ns/100ps
module rtcai_match
  import rtcai_pkg::*;
(
  input wire logic [7:0] min_cnt_i,
  input wire logic [7:0] hour_cnt_i,
  input wire logic [7:0] wday_cnt_i,
  input wire logic [7:0] date_cnt_i,
  input wire logic [7:0] min_alarm_i,
  input wire logic [7:0] hour_alarm_i,
  input wire logic [7:0] wd_alarm_i,
  input wire logic week_or_date_select_i,
  output logic match_o
);
  logic min_ok;
  logic hour_ok;
  logic day_ok;

  // Masked fields always agree; others compare BCD bits only
  assign min_ok = min_alarm_i[RTCAI_B_MASK] |
    (((min_alarm_i ^ min_cnt_i) & RTCAI_MIN_BITS) == RTCAI_ZERO);
  assign hour_ok = hour_alarm_i[RTCAI_B_MASK] |
    (((hour_alarm_i ^ hour_cnt_i) & RTCAI_HD_BITS) == RTCAI_ZERO);

  // Date value or weekday bitmap, per select bit
  always_comb begin
    if (wd_alarm_i[RTCAI_B_MASK]) begin
      day_ok = 1'b1;
    end else if (week_or_date_select_i) begin
      day_ok = ((wd_alarm_i ^ date_cnt_i) & RTCAI_HD_BITS) == RTCAI_ZERO;
    end else begin
      day_ok = (wd_alarm_i & wday_cnt_i & RTCAI_WDAY_BITS) != RTCAI_ZERO;
    end
  end

  // All three masked leaves a match on every minute
  assign match_o = min_ok & hour_ok & day_ok;
endmodule

/* File: rtcai_serial.sv */
/*
 Three-wire serial port: command byte, then data bytes MSB first.
 Assumes the serial clock phases each last two or more reference clocks.
*/
`timescale 1ns/100ps
module rtcai_serial
  import rtcai_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic dio_i,
  output logic dio_o,
  output logic dio_oe_o,
  input wire logic [7:0] rd_data_i,
  output logic [3:0] addr_o,
  output logic wr_o,
  output logic [3:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  rtcai_ser_t state;
  logic sclk_q;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic rise;
  logic fall;
  logic [7:0] next_byte;

  assign rise = ce_i & sclk_i & ~sclk_q;
  assign fall = ce_i & ~sclk_i & sclk_q;
  assign next_byte = {shift[6:0], dio_i};

  // Serial clock history for edge detection
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_i;
    end
  end

  // Bit shifting, command decode and cyclic address step
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= RTCAI_S_CMD;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      addr_o <= 4'h0;
    end else if (!ce_i) begin
      state <= RTCAI_S_CMD; // Partial bytes are dropped
      bit_cnt <= 3'h0;
    end else if (rise) begin
      shift <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == RTCAI_LAST_BIT) begin
        unique case (state)
          RTCAI_S_CMD: begin
            addr_o <= next_byte[7:4];
            if (next_byte[3:0] == RTCAI_MODE_WR) begin
              state <= RTCAI_S_WR;
            end else if (next_byte[3:0] == RTCAI_MODE_RD) begin
              state <= RTCAI_S_RD;
            end else begin
              state <= RTCAI_S_IGN;
            end
          end
          RTCAI_S_WR, RTCAI_S_RD: begin
            addr_o <= addr_o + 4'h1; // F wraps to 0
          end
          RTCAI_S_IGN: begin
            state <= RTCAI_S_IGN;
          end
        endcase
      end
    end
  end

  // Write strobe after each complete data byte
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_o <= 1'b0;
      wr_addr_o <= 4'h0;
      wr_data_o <= 8'h00;
    end else begin
      wr_o <= rise && state == RTCAI_S_WR && bit_cnt == RTCAI_LAST_BIT;
      if (rise && state == RTCAI_S_WR && bit_cnt == RTCAI_LAST_BIT) begin
        wr_addr_o <= addr_o;
        wr_data_o <= next_byte;
      end
    end
  end

  // Read data driven on falling edges, MSB first
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dio_o <= 1'b0;
      dio_oe_o <= 1'b0;
    end else begin
      dio_oe_o <= ce_i && state == RTCAI_S_RD;
      if (fall && state == RTCAI_S_RD) begin
        dio_o <= rd_data_i[RTCAI_LAST_BIT - bit_cnt];
      end
    end
  end
endmodule

/* File: rtcai_top.sv */
/*
 Alarm interrupt block of a real-time clock: alarm and control
 registers behind the serial port, alarm detection, shared interrupt pin.
 Assumes the time base supplies BCD counters with a one-cycle advance
 pulse, and the timer supplies a one-cycle event pulse.
*/
`timescale 1ns/100ps
module rtcai_top
  import rtcai_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic dio_i,
  output logic dio_o,
  output logic dio_oe_o,
  input wire logic [7:0] min_cnt_i,
  input wire logic [7:0] hour_cnt_i,
  input wire logic [7:0] wday_cnt_i,
  input wire logic [7:0] date_cnt_i,
  input wire logic cnt_adv_i,
  input wire logic count_reset_i,
  output logic cnt_wr_o,
  output logic [3:0] cnt_wr_addr_o,
  output logic [7:0] cnt_wr_data_o,
  input wire logic timer_evt_i,
  input wire logic low_voltage_i,
  output logic timer_run_o,
  output logic [1:0] clkout_sel_o,
  output logic [1:0] timer_src_o,
  output logic stop_o,
  output logic irq_b_o,
  output logic irq_b_oe_o
);
  logic [7:0] min_alarm;
  logic [7:0] hour_alarm;
  logic [7:0] wd_alarm;
  logic week_or_date_select;
  logic timer_run;
  logic clkout_sel_hi;
  logic clkout_sel_lo;
  logic timer_src_hi;
  logic timer_src_lo;
  logic alarm_flag;
  logic timer_flag;
  logic low_voltage_flag;
  logic alarm_irq_enable;
  logic timer_irq_enable;
  logic stop;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  logic wr;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic match;
  logic alarm_evt;
  logic flag_wr;
  logic ctrl_wr;

  // Serial port front end
  rtcai_serial u_serial (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .sclk_i(sclk_i),
    .dio_i(dio_i),
    .dio_o(dio_o),
    .dio_oe_o(dio_oe_o),
    .rd_data_i(rd_data),
    .addr_o(rd_addr),
    .wr_o(wr),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // Alarm comparator
  rtcai_match u_match (
    .min_cnt_i(min_cnt_i),
    .hour_cnt_i(hour_cnt_i),
    .wday_cnt_i(wday_cnt_i),
    .date_cnt_i(date_cnt_i),
    .min_alarm_i(min_alarm),
    .hour_alarm_i(hour_alarm),
    .wd_alarm_i(wd_alarm),
    .week_or_date_select_i(week_or_date_select),
    .match_o(match)
  );

  // Register read view, used by the port and by checks
  function automatic logic [7:0] reg_view(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      RTCAI_A_MIN: v = min_cnt_i;
      RTCAI_A_HOUR: v = hour_cnt_i;
      RTCAI_A_WDAY: v = wday_cnt_i;
      RTCAI_A_DATE: v = date_cnt_i;
      RTCAI_A_MIN_ALM: v = min_alarm;
      RTCAI_A_HOUR_ALM: v = hour_alarm;
      RTCAI_A_WD_ALM: v = wd_alarm;
      RTCAI_A_EXT: begin
        v[RTCAI_B_WEEK_OR_DATE_SELECT] = week_or_date_select;
        v[RTCAI_B_TRUN] = timer_run;
        v[RTCAI_B_CSEL+1] = clkout_sel_hi;
        v[RTCAI_B_CSEL] = clkout_sel_lo;
        v[RTCAI_B_TSRC+1] = timer_src_hi;
        v[RTCAI_B_TSRC] = timer_src_lo;
      end
      RTCAI_A_FLAG: begin
        v[RTCAI_B_TF] = timer_flag;
        v[RTCAI_B_AF] = alarm_flag;
        v[RTCAI_B_VLF] = low_voltage_flag;
      end
      RTCAI_A_CTRL: begin
        v[RTCAI_B_TIE] = timer_irq_enable;
        v[RTCAI_B_AIE] = alarm_irq_enable;
        v[RTCAI_B_STOP] = stop;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Process form so flag and setting changes reach the read data at once
  always_comb begin
    rd_data = reg_view(rd_addr);
  end
  assign flag_wr = wr && wr_addr == RTCAI_A_FLAG;
  assign ctrl_wr = wr && wr_addr == RTCAI_A_CTRL;

  // Counter writes go to the time base
  assign cnt_wr_o = wr && (wr_addr == RTCAI_A_MIN ||
    wr_addr == RTCAI_A_HOUR || wr_addr == RTCAI_A_WDAY ||
    wr_addr == RTCAI_A_DATE);
  assign cnt_wr_addr_o = wr_addr;
  assign cnt_wr_data_o = wr_data;

  // Alarm registers, also usable as plain storage
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      min_alarm <= 8'h00;
      hour_alarm <= 8'h00;
      wd_alarm <= 8'h00;
    end else if (wr) begin
      if (wr_addr == RTCAI_A_MIN_ALM) begin
        min_alarm <= wr_data;
      end
      if (wr_addr == RTCAI_A_HOUR_ALM) begin
        hour_alarm <= wr_data;
      end
      if (wr_addr == RTCAI_A_WD_ALM) begin
        wd_alarm <= wr_data;
      end
    end
  end

  // Extension register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      week_or_date_select <= 1'b0;
      timer_run <= 1'b0;
      clkout_sel_hi <= 1'b0;
      clkout_sel_lo <= 1'b0;
      timer_src_hi <= 1'b0;
      timer_src_lo <= 1'b0;
    end else if (wr && wr_addr == RTCAI_A_EXT) begin
      week_or_date_select <= wr_data[RTCAI_B_WEEK_OR_DATE_SELECT];
      timer_run <= wr_data[RTCAI_B_TRUN];
      clkout_sel_hi <= wr_data[RTCAI_B_CSEL+1];
      clkout_sel_lo <= wr_data[RTCAI_B_CSEL];
      timer_src_hi <= wr_data[RTCAI_B_TSRC+1];
      timer_src_lo <= wr_data[RTCAI_B_TSRC];
    end
  end

  // Control register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_irq_enable <= 1'b0;
      alarm_irq_enable <= 1'b0;
      stop <= 1'b0;
    end else if (ctrl_wr) begin
      timer_irq_enable <= wr_data[RTCAI_B_TIE];
      alarm_irq_enable <= wr_data[RTCAI_B_AIE];
      stop <= wr_data[RTCAI_B_STOP];
    end
  end

  // Event only on a counter advance, never while halted or reset
  assign alarm_evt = cnt_adv_i & match & ~stop & ~count_reset_i;

  // Sticky flags: set beats a same-cycle clear, writing 1 is ignored
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_flag <= 1'b0;
    end else if (alarm_evt) begin
      alarm_flag <= 1'b1;
    end else if (flag_wr && !wr_data[RTCAI_B_AF]) begin
      alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_flag <= 1'b0;
    end else if (timer_evt_i) begin
      timer_flag <= 1'b1;
    end else if (flag_wr && !wr_data[RTCAI_B_TF]) begin
      timer_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_voltage_flag <= 1'b0;
    end else if (low_voltage_i) begin
      low_voltage_flag <= 1'b1;
    end else if (flag_wr && !wr_data[RTCAI_B_VLF]) begin
      low_voltage_flag <= 1'b0;
    end
  end

  // Shared open-drain interrupt: pulls low while any enabled source has its flag set
  assign irq_b_o = 1'b0;
  assign irq_b_oe_o = (alarm_flag & alarm_irq_enable) |
    (timer_flag & timer_irq_enable);

  // Settings exported to the timer and clock output logic
  assign timer_run_o = timer_run;
  assign clkout_sel_o = {clkout_sel_hi, clkout_sel_lo};
  assign timer_src_o = {timer_src_hi, timer_src_lo};
  assign stop_o = stop;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_MATCH_SETS: assert property (
    cnt_adv_i && match && !stop && !count_reset_i |=> alarm_flag)
    else $error("Alarm match on advance did not set the flag");
  AST_NO_ADV_NO_SET: assert property (
    !cnt_adv_i && !alarm_flag |=> !alarm_flag)
    else $error("Alarm flag set without a counter advance");
  AST_FLAG_HOLDS: assert property (
    alarm_flag && !(flag_wr && !wr_data[RTCAI_B_AF]) |=> alarm_flag)
    else $error("Alarm flag dropped without a clearing write");
  AST_WRITE_ONE: assert property (
    flag_wr && wr_data[RTCAI_B_AF] && !alarm_flag && !alarm_evt
    |=> !alarm_flag)
    else $error("Writing one changed the alarm flag");
  AST_CLEAR_WORKS: assert property (
    flag_wr && !wr_data[RTCAI_B_AF] && !alarm_evt |=> !alarm_flag)
    else $error("Writing zero did not clear the alarm flag");
  AST_IRQ_LOW: assert property (
    alarm_evt && alarm_irq_enable && !ctrl_wr
    |=> irq_b_oe_o && !irq_b_o)
    else $error("Enabled alarm did not hold the pin low");
  AST_EN_RELEASE: assert property (
    $fell(alarm_irq_enable) && !(timer_flag && timer_irq_enable)
    |-> !irq_b_oe_o)
    else $error("Pin not released when alarm enable dropped");
  AST_FLAG_RELEASE: assert property (
    $fell(alarm_flag) && !(timer_flag && timer_irq_enable)
    |-> !irq_b_oe_o)
    else $error("Pin not released when alarm flag cleared");
  AST_DISABLED_EVT: assert property (
    alarm_evt && !alarm_irq_enable && !ctrl_wr && !timer_flag
    && !timer_evt_i |=> alarm_flag && !irq_b_oe_o)
    else $error("Disabled alarm drove the pin or lost the flag");
  AST_SHARED: assert property (
    timer_flag && timer_irq_enable && !alarm_irq_enable |-> irq_b_oe_o)
    else $error("Timer source could not hold the shared pin");
  AST_HALT: assert property (
    (stop || count_reset_i) && !alarm_flag |=> !alarm_flag)
    else $error("Alarm event while halted or in reset");
  AST_ALL_MASKED: assert property (
    min_alarm[RTCAI_B_MASK] && hour_alarm[RTCAI_B_MASK]
    && wd_alarm[RTCAI_B_MASK] && cnt_adv_i && !stop && !count_reset_i
    |=> alarm_flag)
    else $error("Fully masked alarm missed a minute");
  AST_READ_FLAG: assert property (
    rd_addr == RTCAI_A_FLAG |-> rd_data[RTCAI_B_AF] == alarm_flag)
    else $error("Flag register read does not show the alarm flag");

  COV_ALARM_IRQ: cover property (alarm_evt && alarm_irq_enable);
  COV_ALARM_QUIET: cover property (alarm_evt && !alarm_irq_enable);
  COV_CLEAR: cover property (alarm_flag && flag_wr && !wr_data[RTCAI_B_AF]);
  COV_WEEKDAY: cover property (alarm_evt && !week_or_date_select);
endmodule

/* File: rtcai_host.sv */
/*
 Host model: serial master of the three-wire port, driven by bench tasks.
 Assumes the bench resolves the shared data line and feeds it to dio_i.
*/
`timescale 1ns/100ps
module rtcai_host
  import rtcai_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic dio_i,
  output logic ce_o,
  output logic sclk_o,
  output logic dio_o
);
  logic [7:0] dbuf [0:3];
  // Idle port: no select, serial clock stands still low
  initial begin
    ce_o = 1'b0;
    sclk_o = 1'b0;
    dio_o = 1'b0;
  end
  // One bit: low phase 4 cycles, sample, high phase 2 cycles
  task automatic bit_x(input logic b, output logic r);
    sclk_o <= 1'b0;
    dio_o <= b;
    repeat (4) @(posedge ref_clk_i);
    r = dio_i;
    sclk_o <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask
  // Command byte, then n whole bytes MSB first, address stepping on
  task automatic xfer(input logic [3:0] a, input logic [3:0] m,
      input int n);
    logic [7:0] c;
    logic r;
    c = {a, m};
    ce_o <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    for (int i = 7; i >= 0; i--) bit_x(c[i], r);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        // Toggle own line while the device drives, so stale bits show
        bit_x((m == RTCAI_MODE_RD) ? ~dio_o : dbuf[k][i], r);
        if (m == RTCAI_MODE_RD) dbuf[k][i] = r;
      end
    end
    repeat (2) @(posedge ref_clk_i);
    ce_o <= 1'b0;
    sclk_o <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule

/* File: rtc_alarm_interrupt_tb.sv */
/*
 Self-checking bench of the alarm interrupt block and its serial port.
 Assumes the host model for all register access; bench drives time base.
*/
`timescale 1ns/100ps
module rtc_alarm_interrupt_tb;
  import rtcai_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce, sclk, h_dio, d_o, d_oe, dio_line;
  logic [7:0] mc = 8'h00, hc = 8'h00, wc = 8'h01, dc = 8'h01;
  logic adv = 1'b0, cres = 1'b0, tevt = 1'b0, lowv = 1'b0;
  logic cw, run, stop, irq_b, irq_oe;
  logic [3:0] cw_a, cw_a_s;
  logic [7:0] cw_d, cw_d_s;
  logic [1:0] csel, tsrc;
  int n_mismatch = 0;
  int num_checks = 0;
  // Shared data line: device wins while it drives
  assign dio_line = d_oe ? d_o : h_dio;
  rtcai_host host (.ref_clk_i(ref_clk_i), .dio_i(dio_line), .ce_o(ce),
    .sclk_o(sclk), .dio_o(h_dio));
  rtcai_top uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .sclk_i(sclk), .dio_i(dio_line), .dio_o(d_o), .dio_oe_o(d_oe),
    .min_cnt_i(mc), .hour_cnt_i(hc), .wday_cnt_i(wc), .date_cnt_i(dc),
    .cnt_adv_i(adv), .count_reset_i(cres), .cnt_wr_o(cw),
    .cnt_wr_addr_o(cw_a), .cnt_wr_data_o(cw_d), .timer_evt_i(tevt),
    .low_voltage_i(lowv), .timer_run_o(run), .clkout_sel_o(csel),
    .timer_src_o(tsrc), .stop_o(stop), .irq_b_o(irq_b),
    .irq_b_oe_o(irq_oe));
  // Clock, 100 ns period
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // Catch forwarded counter writes
  always @(posedge ref_clk_i) begin
    if (cw === 1'b1) begin
      cw_a_s <= cw_a;
      cw_d_s <= cw_d;
    end
  end
  task automatic chk_reg(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.dbuf[0] = d;
    host.xfer(a, RTCAI_MODE_WR, 1);
  endtask
  task automatic chk_rd(input string nm, input logic [3:0] a,
      input logic [7:0] e);
    host.xfer(a, RTCAI_MODE_RD, 1);
    chk_reg(nm, e, host.dbuf[0]);
  endtask
  task automatic set_time(input logic [7:0] m, h, w, d);
    @(posedge ref_clk_i);
    mc <= m;
    hc <= h;
    wc <= w;
    dc <= d;
  endtask
  // One minute advance pulse, then let the flag settle
  task automatic tick;
    @(posedge ref_clk_i);
    adv <= 1'b1;
    @(posedge ref_clk_i);
    adv <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic t_reset;
    chk_pin("irq_rst", 1'b0, irq_oe);
    chk_rd("flag_rst", RTCAI_A_FLAG, 8'h00);
    chk_rd("ctrl_rst", RTCAI_A_CTRL, 8'h00);
    chk_rd("ext_rst", RTCAI_A_EXT, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_date;
    wr(RTCAI_A_CTRL, 8'h00);
    set_time(8'h59, 8'h18, 8'h04, 8'h14);
    wr(RTCAI_A_EXT, 8'h40);
    host.dbuf[0] = 8'h59;
    host.dbuf[1] = 8'h18;
    host.dbuf[2] = 8'h14;
    host.xfer(RTCAI_A_MIN_ALM, RTCAI_MODE_WR, 3);
    wr(RTCAI_A_CTRL, 8'h08);
    chk_rd("flag_now", RTCAI_A_FLAG, 8'h00);
    wr(RTCAI_A_WD_ALM, 8'h15);
    tick;
    chk_rd("flag_wday", RTCAI_A_FLAG, 8'h00);
    set_time(8'h19, 8'h18, 8'h04, 8'h15);
    tick;
    chk_rd("flag_min40", RTCAI_A_FLAG, 8'h00);
    set_time(8'h59, 8'h18, 8'h04, 8'h15);
    tick;
    chk_pin("irq_evt", 1'b1, irq_oe);
    chk_rd("flag_evt", RTCAI_A_FLAG, 8'h08);
    wr(RTCAI_A_FLAG, 8'h08);
    chk_rd("flag_w1", RTCAI_A_FLAG, 8'h08);
    chk_pin("irq_hold", 1'b1, irq_oe);
    wr(RTCAI_A_CTRL, 8'h00);
    chk_pin("irq_aie0", 1'b0, irq_oe);
    wr(RTCAI_A_CTRL, 8'h08);
    chk_pin("irq_aie1", 1'b1, irq_oe);
    wr(RTCAI_A_FLAG, 8'h00);
    chk_pin("irq_af0", 1'b0, irq_oe);
    chk_rd("flag_clr", RTCAI_A_FLAG, 8'h00);
    $display("test date done");
  endtask
  task automatic t_week;
    wr(RTCAI_A_CTRL, 8'h00);
    wr(RTCAI_A_EXT, 8'h00);
    host.dbuf[0] = 8'h80;
    host.dbuf[1] = 8'h07;
    host.dbuf[2] = 8'h15;
    host.xfer(RTCAI_A_MIN_ALM, RTCAI_MODE_WR, 3);
    set_time(8'h33, 8'h07, 8'h02, 8'h15);
    tick;
    chk_rd("flag_wd_off", RTCAI_A_FLAG, 8'h00);
    set_time(8'h34, 8'h07, 8'h10, 8'h09);
    tick;
    chk_rd("flag_wd_on", RTCAI_A_FLAG, 8'h08);
    chk_pin("irq_dis", 1'b0, irq_oe);
    wr(RTCAI_A_FLAG, 8'h00);
    $display("test weekday done");
  endtask
  task automatic t_minute;
    host.dbuf[0] = 8'h80;
    host.dbuf[1] = 8'h80;
    host.dbuf[2] = 8'h80;
    host.xfer(RTCAI_A_MIN_ALM, RTCAI_MODE_WR, 3);
    wr(RTCAI_A_CTRL, 8'h02);
    chk_pin("stop_pin", 1'b1, stop);
    tick;
    chk_rd("flag_stop", RTCAI_A_FLAG, 8'h00);
    wr(RTCAI_A_CTRL, 8'h00);
    cres <= 1'b1;
    tick;
    chk_rd("flag_cres", RTCAI_A_FLAG, 8'h00);
    cres <= 1'b0;
    tick;
    chk_rd("flag_each", RTCAI_A_FLAG, 8'h08);
    wr(RTCAI_A_FLAG, 8'h00);
    $display("test minute done");
  endtask
  task automatic t_shared;
    wr(RTCAI_A_CTRL, 8'h10);
    @(posedge ref_clk_i);
    tevt <= 1'b1;
    lowv <= 1'b1;
    @(posedge ref_clk_i);
    tevt <= 1'b0;
    lowv <= 1'b0;
    @(posedge ref_clk_i);
    chk_pin("irq_timer", 1'b1, irq_oe);
    chk_pin("irq_data", 1'b0, irq_b);
    chk_rd("flag_timer", RTCAI_A_FLAG, 8'h12);
    wr(RTCAI_A_FLAG, 8'h00);
    chk_pin("irq_tf0", 1'b0, irq_oe);
    wr(RTCAI_A_CTRL, 8'h00);
    $display("test shared done");
  endtask
  task automatic t_misc;
    wr(RTCAI_A_MIN, 8'h42);
    chk_reg("cnt_wr_addr", 8'h01, {4'h0, cw_a_s});
    chk_reg("cnt_wr_data", 8'h42, cw_d_s);
    wr(RTCAI_A_EXT, 8'h1f);
    chk_reg("ext_pins", 8'h1f, {3'h0, run, csel, tsrc});
    // Unknown mode code: the data byte must be ignored
    host.dbuf[0] = 8'h55;
    host.xfer(RTCAI_A_MIN_ALM, 4'h3, 1);
    host.xfer(RTCAI_A_MIN_ALM, RTCAI_MODE_RD, 3);
    chk_reg("alm_min", 8'h80, host.dbuf[0]);
    chk_reg("alm_hour", 8'h80, host.dbuf[1]);
    chk_reg("alm_wd", 8'h80, host.dbuf[2]);
    wr(RTCAI_A_CTRL, 8'h1a);
    host.xfer(RTCAI_A_CTRL, RTCAI_MODE_RD, 2);
    chk_reg("ctrl_rb", 8'h1a, host.dbuf[0]);
    chk_reg("wrap_zero", 8'h00, host.dbuf[1]);
    $display("test misc done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    n_mismatch++;
    results;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset;
    t_date;
    t_week;
    t_minute;
    t_shared;
    t_misc;
    results;
  end
endmodule
